// ---- hdl/ptsi_regs.svh ----
// register map, field positions and reset values of the package thermal block
// assumes a single-word register port with a small register index
`ifndef PTSI_REGS_SVH
`define PTSI_REGS_SVH

// ----------------------------------------------------------------------------
// register index
// ----------------------------------------------------------------------------
`define PTSI_ADDR_W         2
`define PTSI_IDX_STATE      2'h0
`define PTSI_IDX_CTRL       2'h1

// ----------------------------------------------------------------------------
// state register fields
// ----------------------------------------------------------------------------
`define PTSI_ST_HOT         0
`define PTSI_ST_HOT_LOG     1
`define PTSI_ST_EXT         2
`define PTSI_ST_EXT_LOG     3
`define PTSI_ST_CRIT        4
`define PTSI_ST_CRIT_LOG    5
`define PTSI_ST_TH1         6
`define PTSI_ST_TH1_LOG     7
`define PTSI_ST_TH2         8
`define PTSI_ST_TH2_LOG     9
`define PTSI_ST_PWR         10
`define PTSI_ST_PWR_LOG     11
`define PTSI_ST_READ_LO     16

// ----------------------------------------------------------------------------
// irq control register fields
// ----------------------------------------------------------------------------
`define PTSI_CT_HI_EN       0
`define PTSI_CT_LO_EN       1
`define PTSI_CT_EXT_EN      2
`define PTSI_CT_CRIT_EN     4
`define PTSI_CT_TH1_LO      8
`define PTSI_CT_TH1_EN      15
`define PTSI_CT_TH2_LO      16
`define PTSI_CT_TH2_EN      23
`define PTSI_CT_PWR_EN      24
`define PTSI_CT_WMASK       64'h0000_0000_01FF_FF17
`define PTSI_CT_RESET       64'h0000_0000_0000_0000

// ----------------------------------------------------------------------------
// sticky log bank
// ----------------------------------------------------------------------------
`define PTSI_LOG_N          6
`define PTSI_LOG_HOT        0
`define PTSI_LOG_EXT        1
`define PTSI_LOG_CRIT       2
`define PTSI_LOG_TH1        3
`define PTSI_LOG_TH2        4
`define PTSI_LOG_PWR        5
`define PTSI_LOG_RESET      6'h00

`endif

// ---- hdl/ptsi_pkg.sv ----
// types shared by the package thermal block
// assumes ptsi_regs.svh for all numeric constants
package ptsi_pkg;

  // relative temperature: 0 is activation point, larger is cooler
  typedef logic [6:0]  ptsi_temp_t;
  typedef logic [63:0] ptsi_word_t;

  // live conditions sampled once a cycle for edge detection
  typedef struct packed {
    logic hot;
    logic ext;
    logic crit;
    logic pwr;
    logic th1;
    logic th2;
  } ptsi_cond_s;

endpackage : ptsi_pkg

// ---- hdl/ptsi_log_if.sv ----
// carrier between the register top and its sticky log bank
// assumes one clock domain; set and clear are per-bit single-cycle terms
`timescale 1ns/1ps
interface ptsi_log_if #(
  parameter int N = 6
);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] q;

  modport bank (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface : ptsi_log_if

// ---- hdl/ptsi_log_bank.sv ----
// bank of sticky log bits, cleared by a zero write, set beats clear
// assumes set and clr are synchronous to sys_clk
`timescale 1ns/1ps
`include "ptsi_regs.svh"
module ptsi_log_bank #(
  parameter int N = 6
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  ptsi_log_if.bank  lb
);

  typedef struct packed {
    logic [N-1:0] log;
  } ptsi_bank_s;

  ptsi_bank_s bank_reg;
  ptsi_bank_s bank_next;

  // clear where asked, then set; an event in the clear cycle is kept
  always_comb begin
    bank_next     = bank_reg;
    bank_next.log = (bank_reg.log & ~lb.clr) | lb.set;
  end

  // bank state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bank_reg <= '0;
    end else begin
      bank_reg <= bank_next;
    end
  end

  assign lb.q = bank_reg.log;

endmodule : ptsi_log_bank

// ---- hdl/ptsi_top.sv ----
// package thermal state and irq control register pair
// assumes one register port shared by all cores of the package, inputs
// synchronous to sys_clk, and a single thermal vector fed by thermal_irq
`timescale 1ns/1ps
`include "ptsi_regs.svh"
module ptsi_top (
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  // register port
  input  wire logic                     reg_rd,
  input  wire logic                     reg_wr,
  input  wire logic [`PTSI_ADDR_W-1:0]  reg_addr,
  input  wire ptsi_pkg::ptsi_word_t     reg_wdata,
  output logic                          reg_rvalid,
  output ptsi_pkg::ptsi_word_t          reg_rdata,
  // sensor and platform inputs
  input  wire logic                     hot_active,
  input  wire logic                     ext_hot_active,
  input  wire logic                     bidir_hot_enable,
  input  wire logic                     crit_active,
  input  wire logic                     power_limited,
  input  wire logic                     core_perf_drop,
  input  wire ptsi_pkg::ptsi_temp_t     temp_readout,
  // thermal vector request
  output logic                          thermal_irq
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    ptsi_pkg::ptsi_word_t  ctrl;
    ptsi_pkg::ptsi_cond_s  prev;
    ptsi_pkg::ptsi_word_t  rdata;
    logic                  rvalid;
    logic                  irq;
  } ptsi_top_s;

  ptsi_top_s               top_reg;
  ptsi_top_s               top_next;

  ptsi_log_if #(.N(`PTSI_LOG_N)) log_if ();

  ptsi_pkg::ptsi_cond_s    cond;
  ptsi_pkg::ptsi_temp_t    th1_val;
  ptsi_pkg::ptsi_temp_t    th2_val;
  ptsi_pkg::ptsi_word_t    state_word;
  logic                    wr_state;
  logic                    wr_ctrl;
  logic                    ev_hi;
  logic                    ev_lo;
  logic                    ev_ext;
  logic                    ev_crit;
  logic                    ev_th1;
  logic                    ev_th2;
  logic                    ev_pwr;

  // --------------------------------------------------------------------------
  // live conditions
  // --------------------------------------------------------------------------
  // thresholds held in the control word
  assign th1_val = top_reg.ctrl[`PTSI_CT_TH1_LO +: 7];
  assign th2_val = top_reg.ctrl[`PTSI_CT_TH2_LO +: 7];

  // hotter means a smaller readout, so at-or-above is at-or-below here
  always_comb begin
    cond      = '0;
    cond.hot  = hot_active;
    cond.ext  = ext_hot_active;
    cond.crit = crit_active;
    cond.pwr  = power_limited;
    cond.th1  = (temp_readout <= th1_val);
    cond.th2  = (temp_readout <= th2_val);
  end

  // --------------------------------------------------------------------------
  // register decode
  // --------------------------------------------------------------------------
  // single port seen alike by every core; cores arbitrate before it
  assign wr_state = reg_wr && (reg_addr == `PTSI_IDX_STATE);
  assign wr_ctrl  = reg_wr && (reg_addr == `PTSI_IDX_CTRL);

  // --------------------------------------------------------------------------
  // sticky logs
  // --------------------------------------------------------------------------
  // set terms from live conditions, pwr also from core_perf_drop; zero-write clears, one-write keeps
  always_comb begin
    log_if.set                 = '0;
    log_if.clr                 = '0;
    log_if.set[`PTSI_LOG_HOT]  = cond.hot;
    log_if.set[`PTSI_LOG_EXT]  = cond.ext;
    log_if.set[`PTSI_LOG_CRIT] = cond.crit;
    log_if.set[`PTSI_LOG_TH1]  = cond.th1;
    log_if.set[`PTSI_LOG_TH2]  = cond.th2;
    log_if.set[`PTSI_LOG_PWR]  = cond.pwr | core_perf_drop;
    if (wr_state) begin
      log_if.clr[`PTSI_LOG_HOT]  = ~reg_wdata[`PTSI_ST_HOT_LOG];
      log_if.clr[`PTSI_LOG_EXT]  = ~reg_wdata[`PTSI_ST_EXT_LOG];
      log_if.clr[`PTSI_LOG_CRIT] = ~reg_wdata[`PTSI_ST_CRIT_LOG];
      log_if.clr[`PTSI_LOG_TH1]  = ~reg_wdata[`PTSI_ST_TH1_LOG];
      log_if.clr[`PTSI_LOG_TH2]  = ~reg_wdata[`PTSI_ST_TH2_LOG];
      log_if.clr[`PTSI_LOG_PWR]  = ~reg_wdata[`PTSI_ST_PWR_LOG];
    end
  end

  // log storage
  ptsi_log_bank #(
    .N        (`PTSI_LOG_N)
  ) u_log (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .lb       (log_if.bank)
  );

  // --------------------------------------------------------------------------
  // interrupt events
  // --------------------------------------------------------------------------
  // edges against last cycle's conditions, with core_perf_drop taken as a level, each gated by its enable
  assign ev_hi   = top_reg.ctrl[`PTSI_CT_HI_EN] && cond.hot
                   && !top_reg.prev.hot;
  assign ev_lo   = top_reg.ctrl[`PTSI_CT_LO_EN] && !cond.hot
                   && top_reg.prev.hot;
  assign ev_ext  = top_reg.ctrl[`PTSI_CT_EXT_EN] && bidir_hot_enable
                   && cond.ext && !top_reg.prev.ext;
  assign ev_crit = top_reg.ctrl[`PTSI_CT_CRIT_EN] && cond.crit
                   && !top_reg.prev.crit;
  assign ev_th1  = top_reg.ctrl[`PTSI_CT_TH1_EN]
                   && (cond.th1 != top_reg.prev.th1);
  assign ev_th2  = top_reg.ctrl[`PTSI_CT_TH2_EN]
                   && (cond.th2 != top_reg.prev.th2);
  assign ev_pwr  = top_reg.ctrl[`PTSI_CT_PWR_EN]
                   && ((cond.pwr && !top_reg.prev.pwr) || core_perf_drop);

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  // state word: live bits, logs and readout; the rest reads zero
  always_comb begin
    state_word                           = '0;
    state_word[`PTSI_ST_HOT]             = cond.hot;
    state_word[`PTSI_ST_HOT_LOG]         = log_if.q[`PTSI_LOG_HOT];
    state_word[`PTSI_ST_EXT]             = cond.ext;
    state_word[`PTSI_ST_EXT_LOG]         = log_if.q[`PTSI_LOG_EXT];
    state_word[`PTSI_ST_CRIT]            = cond.crit;
    state_word[`PTSI_ST_CRIT_LOG]        = log_if.q[`PTSI_LOG_CRIT];
    state_word[`PTSI_ST_TH1]             = cond.th1;
    state_word[`PTSI_ST_TH1_LOG]         = log_if.q[`PTSI_LOG_TH1];
    state_word[`PTSI_ST_TH2]             = cond.th2;
    state_word[`PTSI_ST_TH2_LOG]         = log_if.q[`PTSI_LOG_TH2];
    state_word[`PTSI_ST_PWR]             = cond.pwr;
    state_word[`PTSI_ST_PWR_LOG]         = log_if.q[`PTSI_LOG_PWR];
    state_word[`PTSI_ST_READ_LO +: 7]    = temp_readout;
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    top_next      = top_reg;
    top_next.prev = cond;
    // control word keeps only its defined fields
    if (wr_ctrl) begin
      top_next.ctrl = reg_wdata & `PTSI_CT_WMASK;
    end
    // read answer one cycle after the strobe; unmapped index reads zero
    top_next.rvalid = reg_rd;
    top_next.rdata  = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `PTSI_IDX_STATE: top_next.rdata = state_word;
        `PTSI_IDX_CTRL:  top_next.rdata = top_reg.ctrl;
        default:         top_next.rdata = '0;
      endcase
    end
    // every source merges onto the one thermal request
    top_next.irq = ev_hi | ev_lo | ev_ext | ev_crit
                   | ev_th1 | ev_th2 | ev_pwr;
  end

  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      top_reg      <= '0;
      top_reg.ctrl <= `PTSI_CT_RESET;
    end else begin
      top_reg <= top_next;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign reg_rvalid  = top_reg.rvalid;
  assign reg_rdata   = top_reg.rdata;
  assign thermal_irq = top_reg.irq;

endmodule : ptsi_top

// ---- test/ptsi_top_props.sv ----
// assertions on the ports of the package thermal block
// assumes the ptsi_top port list; bound to it below the module
`timescale 1ns/1ps
`include "ptsi_regs.svh"
module ptsi_top_props (
  input wire logic                    sys_clk,
  input wire logic                    resetn,
  input wire logic                    reg_rd,
  input wire logic                    reg_wr,
  input wire logic [`PTSI_ADDR_W-1:0] reg_addr,
  input wire ptsi_pkg::ptsi_word_t    reg_wdata,
  input wire logic                    reg_rvalid,
  input wire ptsi_pkg::ptsi_word_t    reg_rdata,
  input wire logic                    hot_active,
  input wire logic                    ext_hot_active,
  input wire logic                    bidir_hot_enable,
  input wire logic                    crit_active,
  input wire logic                    power_limited,
  input wire logic                    core_perf_drop,
  input wire ptsi_pkg::ptsi_temp_t    temp_readout,
  input wire logic                    thermal_irq
);
  // a read of the state word
  logic rd_st;
  assign rd_st = reg_rd && (reg_addr == `PTSI_IDX_STATE);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // live bits equal the inputs at the read edge
  property p_hot_live; rd_st |=> reg_rdata[0] == $past(hot_active); endproperty
  a_hot_live: assert property (p_hot_live) else $error("hot bit wrong");
  property p_ext_live; rd_st |=> reg_rdata[2] == $past(ext_hot_active); endproperty
  a_ext_live: assert property (p_ext_live) else $error("ext bit wrong");
  property p_crit_live; rd_st |=> reg_rdata[4] == $past(crit_active); endproperty
  a_crit_live: assert property (p_crit_live) else $error("crit bit wrong");
  property p_pwr_live; rd_st |=> reg_rdata[10] == $past(power_limited); endproperty
  a_pwr_live: assert property (p_pwr_live) else $error("pwr bit wrong");
  property p_readout; rd_st |=> reg_rdata[22:16] == $past(temp_readout); endproperty
  a_readout: assert property (p_readout) else $error("readout wrong");
  // logs seen by a read one edge after the cause
  property p_hot_log; hot_active ##1 rd_st |=> reg_rdata[1]; endproperty
  a_hot_log: assert property (p_hot_log) else $error("hot log missed");
  property p_crit_log; crit_active ##1 rd_st |=> reg_rdata[5]; endproperty
  a_crit_log: assert property (p_crit_log) else $error("crit log missed");
  // unmapped indexes and bits 63:25 of any read return zero
  property p_unmapped; reg_rd && reg_addr[1] |=> reg_rvalid && reg_rdata == '0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
  property p_upper; reg_rvalid |-> reg_rdata[63:25] == '0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
endmodule : ptsi_top_props

bind ptsi_top ptsi_top_props ptsi_top_props_i (.sys_clk(sys_clk), .resetn(resetn),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .hot_active(hot_active),
  .ext_hot_active(ext_hot_active), .bidir_hot_enable(bidir_hot_enable),
  .crit_active(crit_active), .power_limited(power_limited),
  .core_perf_drop(core_perf_drop), .temp_readout(temp_readout),
  .thermal_irq(thermal_irq));

// ---- test/ptsi_sensor_model.sv ----
// sensor and platform agents facing the package thermal block
// assumes its tasks are called off the rising clock edge
`timescale 1ns/1ps
module ptsi_sensor_model (
  output logic                 hot_active,
  output logic                 ext_hot_active,
  output logic                 bidir_hot_enable,
  output logic                 crit_active,
  output logic                 power_limited,
  output logic                 core_perf_drop,
  output ptsi_pkg::ptsi_temp_t temp_readout
);
  // quiet levels and a cool readout at start
  initial begin
    {hot_active, ext_hot_active, bidir_hot_enable} = 3'h0;
    {crit_active, power_limited, core_perf_drop} = 3'h0;
    temp_readout = 7'h51;
  end
  // move one agent line by index
  task automatic set_line(input int idx, input logic v);
    case (idx)
      0: hot_active = v;
      1: ext_hot_active = v;
      2: bidir_hot_enable = v;
      3: crit_active = v;
      4: power_limited = v;
      default: core_perf_drop = v;
    endcase
  endtask : set_line
  // new readout, larger is cooler
  task automatic set_temp(input ptsi_pkg::ptsi_temp_t t);
    temp_readout = t;
  endtask : set_temp
endmodule : ptsi_sensor_model

// ---- test/test_package_thermal_status_interrupt.sv ----
// self-checking bench for the package thermal register pair
// assumes ptsi_top, its checker and the sensor model
`timescale 1ns/1ps
module test_package_thermal_status_interrupt;
  logic                 sys_clk = 1'b0;
  logic                 resetn, reg_rd, reg_wr, reg_rvalid, thermal_irq, en;
  logic [1:0]           reg_addr;
  ptsi_pkg::ptsi_word_t reg_wdata, reg_rdata, base;
  logic                 hot_active, ext_hot_active, bidir_hot_enable;
  logic                 crit_active, power_limited, core_perf_drop;
  ptsi_pkg::ptsi_temp_t temp_readout;
  int                   fails, checks_done, i, lo;
  int                   src[4] = '{0, 1, 3, 4};
  int                   sb[4] = '{0, 2, 4, 10};
  ptsi_pkg::ptsi_word_t enb[4] = '{64'h1, 64'h4, 64'h10, 64'h0100_0000};

  always #20 sys_clk = ~sys_clk;

  ptsi_top ptsi_top_i (.sys_clk(sys_clk), .resetn(resetn), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .hot_active(hot_active),
    .ext_hot_active(ext_hot_active), .bidir_hot_enable(bidir_hot_enable),
    .crit_active(crit_active), .power_limited(power_limited),
    .core_perf_drop(core_perf_drop), .temp_readout(temp_readout),
    .thermal_irq(thermal_irq));
  ptsi_sensor_model ptsi_sensor_model_i (.hot_active(hot_active),
    .ext_hot_active(ext_hot_active), .bidir_hot_enable(bidir_hot_enable),
    .crit_active(crit_active), .power_limited(power_limited),
    .core_perf_drop(core_perf_drop), .temp_readout(temp_readout));

  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic chk(input ptsi_pkg::ptsi_word_t seen, input ptsi_pkg::ptsi_word_t exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input ptsi_pkg::ptsi_word_t d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input ptsi_pkg::ptsi_word_t exp);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk(ptsi_pkg::ptsi_word_t'(reg_rvalid), 64'h1);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic irq(input logic e);
    @(negedge sys_clk);
    chk(ptsi_pkg::ptsi_word_t'(thermal_irq), ptsi_pkg::ptsi_word_t'(e));
  endtask : irq
  task automatic tend(input string s);
    $display("test %s done, fails=%0d", s, fails);
  endtask : tend
  task automatic conclude;
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // watchdog on the whole run
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    conclude();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {resetn, reg_rd, reg_wr, reg_addr, reg_wdata} = '0;
    base = 64'h0000_0000_0051_0000;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    rd(2'h0, base);
    rd(2'h1, 64'h0);
    wr(2'h3, '1);
    rd(2'h3, 64'h0);
    wr(2'h1, '1);
    rd(2'h1, 64'h0000_0000_01FF_FF17);
    wr(2'h1, 64'h0);
    rd(2'h0, base | 64'h280);
    wr(2'h0, '1);
    rd(2'h0, base | 64'h280);
    wr(2'h0, 64'h0);
    rd(2'h0, base);
    tend("map");
    // hot, ext, crit and pwr sources, each with and without its enable
    ptsi_sensor_model_i.set_line(2, 1'b1);
    for (int k = 0; k < 8; k++) begin
      i = k % 4;
      en = (k < 4);
      wr(2'h1, en ? enb[i] : 64'h0);
      ptsi_sensor_model_i.set_line(src[i], 1'b1);
      irq(en);
      rd(2'h0, base | (64'h3 << sb[i]));
      ptsi_sensor_model_i.set_line(src[i], 1'b0);
      irq(1'b0);
      wr(2'h0, '1);
      rd(2'h0, base | (64'h2 << sb[i]));
      wr(2'h0, 64'h0);
      rd(2'h0, base);
    end
    tend("sources");
    // cooling edge, feature off, core drop
    wr(2'h1, 64'h2);
    ptsi_sensor_model_i.set_line(0, 1'b1);
    irq(1'b0);
    ptsi_sensor_model_i.set_line(0, 1'b0);
    irq(1'b1);
    ptsi_sensor_model_i.set_line(2, 1'b0);
    wr(2'h1, 64'h4);
    ptsi_sensor_model_i.set_line(1, 1'b1);
    irq(1'b0);
    rd(2'h0, base | 64'hE);
    ptsi_sensor_model_i.set_line(1, 1'b0);
    wr(2'h1, 64'h0100_0000);
    ptsi_sensor_model_i.set_line(5, 1'b1);
    irq(1'b1);
    ptsi_sensor_model_i.set_line(5, 1'b0);
    rd(2'h0, base | 64'h80A);
    wr(2'h0, 64'h0);
    tend("edges");
    // thresholds crossed both ways at the boundary value
    for (int j = 0; j < 2; j++) begin
      lo = j ? 16 : 8;
      wr(2'h1, (64'h50 << lo) | (64'h1 << (lo + 7)));
      ptsi_sensor_model_i.set_temp(7'h50);
      irq(1'b1);
      rd(2'h0, 64'h0050_0000 | (64'h3 << (6 + 2 * j)));
      ptsi_sensor_model_i.set_temp(7'h51);
      irq(1'b1);
      rd(2'h0, base | (64'h2 << (6 + 2 * j)));
      wr(2'h0, 64'h0);
    end
    tend("thresholds");
    // second reset clears control and logs
    ptsi_sensor_model_i.set_line(0, 1'b1);
    irq(1'b0);
    ptsi_sensor_model_i.set_line(0, 1'b0);
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    rd(2'h1, 64'h0);
    rd(2'h0, base);
    tend("reset");
    conclude();
  end
endmodule : test_package_thermal_status_interrupt
